// ---- rtl/dbs_pkg.sv ----
`default_nettype none
package dbs_pkg;
    // Bus geometry of the two variants; a byte lane is nine bits wide
    localparam int DATA_W_WIDE     = 36;
    localparam int DATA_W_NARROW   = 18;
    localparam int MASK_W_WIDE     = 4;
    localparam int MASK_W_NARROW   = 2;
    localparam int BYTE_W          = 9;
    // Upper address bits, not counting the burst start bit
    localparam int UPPER_W_WIDE    = 18;
    localparam int UPPER_W_NARROW  = 19;
    // Position of the burst start bit inside a full word address
    localparam int BURST_BIT_POS   = 0;
    // Input clock edges from load to the launch of the first read word
    localparam int READ_LAT_CYCLES = 2;
    // Edges counted with the output clock reading high; the next such edge selects K timing
    localparam int MODE_HOLD_CYCLES = 4;
    localparam int MODE_CNT_W       = 3;
    // Values after reset
    localparam logic RST_KMODE      = 1'b0;
    localparam logic RST_TOGGLE     = 1'b0;
endpackage : dbs_pkg
`default_nettype wire

// ---- rtl/dbs_sram_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module dbs_sram_port
    import dbs_pkg::*;
#(
    parameter bit WIDE_VARIANT = 1'b1
) (
    input  wire logic clock_in,
    input  wire logic rst_in,
    input  wire logic out_clk_in,
    input  wire logic load_strobe_n_in,
    input  wire logic read_not_write_in,
    input  wire logic burst_start_bit_in,
    input  wire logic [(WIDE_VARIANT ? dbs_pkg::UPPER_W_WIDE
                      : dbs_pkg::UPPER_W_NARROW)-1:0] addr_in,
    input  wire logic [(WIDE_VARIANT ? dbs_pkg::MASK_W_WIDE
                      : dbs_pkg::MASK_W_NARROW)-1:0] byte_write_mask_n_in,
    input  wire logic [(WIDE_VARIANT ? dbs_pkg::DATA_W_WIDE
                      : dbs_pkg::DATA_W_NARROW)-1:0] data_io_in,
    output logic      [(WIDE_VARIANT ? dbs_pkg::DATA_W_WIDE
                      : dbs_pkg::DATA_W_NARROW)-1:0] data_io_out,
    output logic      data_io_oe_out,
    output logic      echo_strobe_p_out,
    output logic      echo_strobe_n_out
);
    import dbs_pkg::*;

    // Variant geometry
    localparam int DW    = WIDE_VARIANT ? DATA_W_WIDE : DATA_W_NARROW;
    localparam int MW    = WIDE_VARIANT ? MASK_W_WIDE : MASK_W_NARROW;
    localparam int AW    = WIDE_VARIANT ? UPPER_W_WIDE : UPPER_W_NARROW;
    localparam int DEPTH = 2 ** (AW + 1);
    localparam int LAT   = READ_LAT_CYCLES;

    typedef logic [AW:0] dbs_addr_t;
    typedef logic [DW-1:0] dbs_word_t;

    // Input clock domain state
    typedef struct packed {
        logic [1:0]                csync;
        logic [MODE_CNT_W-1:0]     hicnt;
        logic                      kmode;
        logic [LAT-1:0]            rdv;
        logic [LAT-1:0][AW:0]      rda;
        logic                      wr0;
        dbs_addr_t                 wa0;
        logic                      wr1;
        dbs_addr_t                 wa1;
        logic                      launch;
        dbs_word_t                 rw0;
        dbs_word_t                 rw1;
        logic                      tog;
        logic                      pos_oe;
        dbs_word_t                 pos_word;
    } dbs_k_t;

    // Output clock domain state
    typedef struct packed {
        logic [2:0] tsync;
        logic       launch;
        dbs_word_t  w0;
        dbs_word_t  w1;
        logic       pos_oe;
        dbs_word_t  pos_word;
    } dbs_c_t;

    dbs_k_t    k_r;
    dbs_k_t    k_nxt;
    dbs_c_t    c_r;
    dbs_c_t    c_nxt;
    dbs_word_t mem [0:DEPTH-1];
    dbs_word_t neg_data_r;
    logic [MW-1:0] neg_mask_n_r;
    dbs_word_t neg_word_r;
    logic      neg_oe_r;
    dbs_word_t c_neg_word_r;
    logic      c_neg_oe_r;
    dbs_addr_t load_addr;
    logic      load_seen;
    logic      c_edge;

    // Lane merge: a low mask bit lets its lane through
    function automatic dbs_word_t lane_merge(input dbs_word_t old_w,
                                             input dbs_word_t new_w,
                                             input logic [MW-1:0] m_n);
        dbs_word_t r;
        r = old_w;
        for (int i = 0; i < MW; i++) begin
            if (!m_n[i]) begin
                r[i*BYTE_W +: BYTE_W] = new_w[i*BYTE_W +: BYTE_W];
            end
        end
        return r;
    endfunction : lane_merge

    // Load decode at the rising input edge only
    assign load_addr = {addr_in, burst_start_bit_in};
    assign load_seen = !load_strobe_n_in;

    // Next state of the input clock domain
    always_comb begin
        k_nxt = k_r;
        // Mode detect: output clock must sit high for several edges
        // Several samples, so a slow running clock is not taken as held
        k_nxt.csync = {k_r.csync[0], out_clk_in};
        if (!k_r.csync[1]) begin
            k_nxt.hicnt = '0;
            k_nxt.kmode = 1'b0;
        end else if (k_r.hicnt != MODE_CNT_W'(MODE_HOLD_CYCLES)) begin
            k_nxt.hicnt = k_r.hicnt + MODE_CNT_W'(1);
        end else begin
            k_nxt.kmode = 1'b1;
        end
        // Read pipeline, address held with its start word
        k_nxt.rdv[0] = load_seen && read_not_write_in;
        k_nxt.rda[0] = load_addr;
        for (int i = 1; i < LAT; i++) begin
            k_nxt.rdv[i] = k_r.rdv[i-1];
            k_nxt.rda[i] = k_r.rda[i-1];
        end
        // Write: first word next cycle, second word one edge later
        k_nxt.wr0 = load_seen && !read_not_write_in;
        k_nxt.wa0 = load_addr;
        k_nxt.wr1 = k_r.wr0;
        k_nxt.wa1 = k_r.wa0 ^ dbs_addr_t'(1 << BURST_BIT_POS);
        // Both words are fetched together so a later write cannot split them
        // Fetch both words of the burst at the end of the latency
        k_nxt.launch = k_r.rdv[LAT-1];
        if (k_r.rdv[LAT-1]) begin
            k_nxt.rw0 = mem[k_r.rda[LAT-1]];
            k_nxt.rw1 = mem[k_r.rda[LAT-1] ^
                            dbs_addr_t'(1 << BURST_BIT_POS)];
            k_nxt.tog = !k_r.tog;
        end
        // Second word goes out on the true clock edge
        k_nxt.pos_oe   = k_r.launch;
        k_nxt.pos_word = k_r.rw1;
    end

    // Register the input clock domain
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            k_r       <= '0;
            k_r.kmode <= RST_KMODE;
            k_r.tog   <= RST_TOGGLE;
        end else begin
            k_r <= k_nxt;
        end
    end

    // Storage; the newer write is placed last so it wins an overlap
    // Contents are not reset, so a read of an unwritten word is unknown
    always_ff @(posedge clock_in) begin
        if (k_r.wr1) begin
            mem[k_r.wa1] <= lane_merge(mem[k_r.wa1], neg_data_r,
                                       neg_mask_n_r);
        end
        if (k_r.wr0) begin
            mem[k_r.wa0] <= lane_merge(mem[k_r.wa0], data_io_in,
                                       byte_write_mask_n_in);
        end
    end

    // Complement edge: second write word and first read word
    // Falling-edge flops stand in for the rising edge of the complement
    always_ff @(negedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            neg_data_r   <= '0;
            neg_mask_n_r <= '1;
            neg_word_r   <= '0;
            neg_oe_r     <= 1'b0;
        end else begin
            neg_data_r   <= data_io_in;
            neg_mask_n_r <= byte_write_mask_n_in;
            neg_word_r   <= k_r.rw0;
            neg_oe_r     <= k_r.launch;
        end
    end

    // Output clock side: toggle crossing, word pair held steady by sender
    // Reads must be three input cycles apart here, or a pair is skipped
    // The synchroniser freezes while the output clock is held high, so on
    // resume one stale pair may be replayed while input timing still rules
    assign c_edge = c_r.tsync[1] ^ c_r.tsync[2];

    always_comb begin
        c_nxt          = c_r;
        c_nxt.tsync    = {c_r.tsync[1:0], k_r.tog};
        c_nxt.launch   = c_edge;
        if (c_edge) begin
            c_nxt.w0 = k_r.rw0;
            c_nxt.w1 = k_r.rw1;
        end
        c_nxt.pos_oe   = c_r.launch;
        c_nxt.pos_word = c_r.w1;
    end

    always_ff @(posedge out_clk_in or posedge rst_in) begin
        if (rst_in) begin
            c_r <= '0;
        end else begin
            c_r <= c_nxt;
        end
    end

    // First word on the complement of the output clock
    always_ff @(negedge out_clk_in or posedge rst_in) begin
        if (rst_in) begin
            c_neg_word_r <= '0;
            c_neg_oe_r   <= 1'b0;
        end else begin
            c_neg_word_r <= c_r.w0;
            c_neg_oe_r   <= c_r.launch;
        end
    end

    // Pin drive: clock level picks the edge register, mode picks the pair
    // The level mux keeps each word on the pins for a full half cycle
    always_comb begin
        if (k_r.kmode) begin
            data_io_out    = clock_in ? k_r.pos_word : neg_word_r;
            data_io_oe_out = clock_in ? k_r.pos_oe : neg_oe_r;
        end else begin
            data_io_out    = out_clk_in ? c_r.pos_word : c_neg_word_r;
            data_io_oe_out = out_clk_in ? c_r.pos_oe : c_neg_oe_r;
        end
    end

    // Echo clocks follow the launching clock, tristate or not
    // Kept combinational so their edges line up with the data mux
    assign echo_strobe_p_out = k_r.kmode ? clock_in : out_clk_in;
    assign echo_strobe_n_out = !echo_strobe_p_out;

    // Checks in the input clock domain, then the output clock domain
    // Each domain's checks use its own clock and the shared reset
    localparam int A_LAT = READ_LAT_CYCLES;

    a_load_capture: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (!load_strobe_n_in && read_not_write_in)
        |=> (k_r.rdv[0] && k_r.rda[0] ==
             $past({addr_in, burst_start_bit_in})))
        else $error("read load not captured with its address");

    a_nop_ignored: assert property (
        @(posedge clock_in) disable iff (rst_in)
        load_strobe_n_in |=> (!k_r.rdv[0] && !k_r.wr0))
        else $error("idle cycle started a transaction");

    a_write_select: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (!load_strobe_n_in && !read_not_write_in)
        |=> (k_r.wr0 && !k_r.rdv[0] && k_r.wa0 ==
             $past({addr_in, burst_start_bit_in})))
        else $error("write load took the wrong direction");

    a_burst_pair: assert property (
        @(posedge clock_in) disable iff (rst_in)
        k_r.wr0 |=> (k_r.wr1 && k_r.wa1 ==
                     ($past(k_r.wa0) ^ dbs_addr_t'(1))))
        else $error("second write word missing or misaddressed");

    // The launch flop is seen one edge after the edge that loads it
    a_read_latency: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (!load_strobe_n_in && read_not_write_in)
        |=> ##A_LAT (k_r.launch ##1 k_r.pos_oe))
        else $error("read burst not launched at the fixed latency");

    a_second_word: assert property (
        @(posedge clock_in) disable iff (rst_in)
        k_r.launch |=> (k_r.pos_oe && k_r.pos_word == $past(k_r.rw1)))
        else $error("second read word not on the true edge");

    // The complement flops were loaded half a cycle before this edge
    a_first_word: assert property (
        @(posedge clock_in) disable iff (rst_in)
        k_r.launch |-> (neg_oe_r && neg_word_r == k_r.rw0))
        else $error("first read word not on the complement edge");

    a_mode_entry: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (k_r.csync[1] && k_r.hicnt == MODE_CNT_W'(MODE_HOLD_CYCLES))
        |=> k_r.kmode)
        else $error("held output clock did not select input timing");

    a_mode_leave: assert property (
        @(posedge clock_in) disable iff (rst_in)
        !k_r.csync[1] |=> (!k_r.kmode && k_r.hicnt == '0))
        else $error("toggling output clock left input timing on");

    // Mode counter only advances while the output clock reads high
    a_mode_count: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (k_r.csync[1] && k_r.hicnt != MODE_CNT_W'(MODE_HOLD_CYCLES))
        |=> (!k_r.kmode && k_r.hicnt == $past(k_r.hicnt) + MODE_CNT_W'(1)))
        else $error("mode counter did not advance");

    // True-edge drive only in the cycle after a launch
    a_k_oe_window: assert property (
        @(posedge clock_in) disable iff (rst_in)
        k_r.pos_oe |-> $past(k_r.launch))
        else $error("second read word driven outside its burst");

    a_c_launch: assert property (
        @(posedge out_clk_in) disable iff (rst_in)
        (c_r.tsync[1] ^ c_r.tsync[2]) |=> (c_r.launch ##1 c_r.pos_oe))
        else $error("output clock side missed a read burst");

    // Output clock checks are silent while that clock is held high
    a_c_first_word: assert property (
        @(posedge out_clk_in) disable iff (rst_in)
        c_r.launch |-> (c_neg_oe_r && c_neg_word_r == c_r.w0))
        else $error("first read word not on the output complement edge");

    a_c_second_word: assert property (
        @(posedge out_clk_in) disable iff (rst_in)
        c_r.launch |=> (c_r.pos_oe && c_r.pos_word == $past(c_r.w1)))
        else $error("second read word not on the output true edge");

    a_c_oe_window: assert property (
        @(posedge out_clk_in) disable iff (rst_in)
        c_r.pos_oe |-> $past(c_r.launch))
        else $error("output side drove a word outside its burst");

endmodule : dbs_sram_port
`default_nettype wire

// ---- sim/dbs_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Controller side: output clock source and resolution of the shared bus
module dbs_ctrl_model (
    input  wire logic        hold_high_in,
    input  wire logic        dev_oe_in,
    input  wire logic [35:0] dev_data_in,
    input  wire logic        drv_en_in,
    input  wire logic [35:0] drv_data_in,
    output logic             out_clk_out,
    output logic      [35:0] bus_out
);
    logic [35:0] last_q;
    // Clock-circuit disable stays inactive; the block has no such input
    // Output clock of 12 ns; held steadily high to select input clock timing
    initial begin
        out_clk_out = 1'b1;
        #3.1;
        forever begin
            #6;
            out_clk_out = hold_high_in ? 1'b1 : ~out_clk_out;
        end
    end
    // Remember the last driven value of the bus
    always @* begin
        if (dev_oe_in)
            last_q = dev_data_in;
        else if (drv_en_in)
            last_q = drv_data_in;
    end
    // A released bus shows the inverse, so stale data never matches
    assign bus_out = (dev_oe_in | drv_en_in) ? last_q : ~last_q;
endmodule : dbs_ctrl_model
`default_nettype wire

// ---- sim/ddr_two_word_burst_sram_port_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddr_two_word_burst_sram_port_test;
    import dbs_pkg::*;
    logic        clock_in = 1'b0;
    logic        rst_in   = 1'b1;
    logic        hold_hi  = 1'b0;
    logic        load_n   = 1'b1;
    logic        rnw      = 1'b0;
    logic        start    = 1'b0;
    logic        drv_en   = 1'b0;
    logic [17:0] addr     = 18'h0_0000;
    logic [3:0]  mask_n   = 4'hf;
    logic [35:0] drv_data = 36'h0_0000_0000;
    logic [35:0] bus, data_out;
    logic        oe, echo_p, echo_n, out_clk;
    logic [17:0] n_data;
    logic        n_oe;
    int          err_count = 0;
    int          cmp_count = 0;
    logic [35:0] mem [int];
    logic [17:0] pool [4];

    dbs_sram_port #(.WIDE_VARIANT(1'b1)) i_dut (
        .clock_in(clock_in), .rst_in(rst_in), .out_clk_in(out_clk),
        .load_strobe_n_in(load_n), .read_not_write_in(rnw),
        .burst_start_bit_in(start), .addr_in(addr),
        .byte_write_mask_n_in(mask_n), .data_io_in(bus),
        .data_io_out(data_out), .data_io_oe_out(oe),
        .echo_strobe_p_out(echo_p), .echo_strobe_n_out(echo_n));
    dbs_ctrl_model i_ctrl (
        .hold_high_in(hold_hi), .dev_oe_in(oe), .dev_data_in(data_out),
        .drv_en_in(drv_en), .drv_data_in(drv_data),
        .out_clk_out(out_clk), .bus_out(bus));
    // Narrow variant on the same stimulus; its lanes are the low two
    dbs_sram_port #(.WIDE_VARIANT(1'b0)) i_dut_narrow (
        .clock_in(clock_in), .rst_in(rst_in), .out_clk_in(out_clk),
        .load_strobe_n_in(load_n), .read_not_write_in(rnw),
        .burst_start_bit_in(start), .addr_in({1'b0, addr}),
        .byte_write_mask_n_in(mask_n[1:0]), .data_io_in(bus[17:0]),
        .data_io_out(n_data), .data_io_oe_out(n_oe),
        .echo_strobe_p_out(), .echo_strobe_n_out());

    // Input clock, 50 MHz
    initial begin
        forever #10 clock_in = ~clock_in;
    end

    task automatic final_report;
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    task automatic check(string name, logic [35:0] exp, logic [35:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Lanes whose active-low mask is low take the new bits
    function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] n,
                                          logic [3:0] m);
        merge = o;
        for (int i = 0; i < 4; i++)
            if (!m[i])
                merge[9*i+:9] = n[9*i+:9];
    endfunction : merge

    // Echo follows the input clock when held high, else the output clock
    task automatic check_echo;
        logic exp_clk;
        #1;
        exp_clk = hold_hi ? clock_in : out_clk;
        check("echo_p", 36'(exp_clk), 36'(echo_p));
        check("echo_n", 36'(!exp_clk), 36'(echo_n));
    endtask : check_echo

    // Write burst; ld high makes it a no-operation that must change nothing
    task automatic wr(logic [17:0] a, logic s, logic [35:0] w0, w1,
                      logic [3:0] m0, m1, logic ld);
        int k;
        k = int'({a, s});
        @(negedge clock_in);
        load_n = ld;
        rnw    = 1'b0;
        addr   = a;
        start  = s;
        // Address is scrambled after the load edge; it must be ignored
        @(negedge clock_in);
        load_n   = 1'b1;
        addr     = ~a;
        drv_en   = 1'b1;
        drv_data = w0;
        mask_n   = m0;
        @(posedge clock_in);
        #5;
        drv_data = w1;
        mask_n   = m1;
        @(negedge clock_in);
        #5;
        drv_en = 1'b0;
        mask_n = 4'hf;
        if (!ld) begin
            mem[k]     = merge(mem[k], w0, m0);
            mem[k ^ 1] = merge(mem[k ^ 1], w1, m1);
        end
    endtask : wr

    // Read burst; word0 at the loaded address, word1 at its partner
    task automatic rd(logic [17:0] a, logic s);
        int k;
        int n;
        k = int'({a, s});
        @(negedge clock_in);
        load_n = 1'b0;
        rnw    = 1'b1;
        addr   = a;
        start  = s;
        @(negedge clock_in);
        load_n = 1'b1;
        addr   = ~a;
        if (hold_hi) begin
            repeat (2) @(posedge clock_in);
            @(negedge clock_in);
            #2;
            check("oe0", 36'h1, {35'h0, oe});
            check("word0", mem[k], data_out);
            check("n_oe0", 36'h1, 36'(n_oe));
            check("n_w0", {18'h0, mem[k][17:0]}, 36'(n_data));
            @(posedge clock_in);
            #2;
            check("word1", mem[k ^ 1], data_out);
            check("n_w1", {18'h0, mem[k ^ 1][17:0]}, 36'(n_data));
            @(negedge clock_in);
            #2;
            check("oe_off", 36'h0, {35'h0, oe});
        end else begin
            // Bounded wait for the crossing into the output clock domain
            for (n = 0; n < 40 && !oe; n++) begin
                @(out_clk);
                #1;
            end
            if (!oe) begin
                err_count++;
                final_report();
            end
            check("c_word0", mem[k], data_out);
            check("n_c_w0", {18'h0, mem[k][17:0]}, 36'(n_data));
            @(posedge out_clk);
            #1;
            check("c_word1", mem[k ^ 1], data_out);
            check("n_c_w1", {18'h0, mem[k ^ 1][17:0]}, 36'(n_data));
        end
    endtask : rd

    // Watchdog against a hang
    initial begin
        #400_000;
        err_count++;
        final_report();
    end

    initial begin
        int j;
        logic [3:0] m;
        void'($urandom(32'h066e));
        repeat (2) @(posedge clock_in);
        #1;
        check("rst_oe", 36'h0, {35'h0, oe});
        check("rst_data", 36'h0, data_out);
        check_echo();
        @(negedge clock_in);
        rst_in  = 1'b0;
        hold_hi = 1'b1;
        repeat (8) @(negedge clock_in);
        check_echo();
        // Fill a small address pool with full words
        for (int i = 0; i < 4; i++) begin
            pool[i] = 18'($urandom);
            wr(pool[i], 1'b0, 36'({$urandom, $urandom}),
               36'({$urandom, $urandom}), 4'h0, 4'h0, 1'b0);
        end
        // Random writes with masks, reads and no-operations
        for (int i = 0; i < 40; i++) begin
            j = $urandom % 4;
            m = 4'($urandom);
            case ($urandom % 3)
                0: wr(pool[j], 1'($urandom), 36'({$urandom, $urandom}),
                      36'({$urandom, $urandom}), m, ~m, 1'b0);
                1: rd(pool[j], 1'($urandom));
                default: wr(pool[j], 1'($urandom), 36'h0_0000_0000,
                            36'h0_0000_0000, 4'h0, 4'h0, 1'b1);
            endcase
            check_echo();
        end
        // Every word from both starting positions
        for (int i = 0; i < 8; i++)
            rd(pool[i / 2], 1'(i));
        // Output clock timing with the clock running
        hold_hi = 1'b0;
        // Leaving input timing takes up to five sampled edges
        repeat (8) @(negedge clock_in);
        check_echo();
        rd(pool[0], 1'b1);
        rd(pool[3], 1'b0);
        final_report();
    end
endmodule : ddr_two_word_burst_sram_port_test
`default_nettype wire
